/* hw/xpt_cfg_pkg.sv */
// shared constants for the crosspoint two-wire configuration port
package xpt_cfg_pkg;
  localparam int NUM_INPUTS = 8;
  localparam int NUM_OUTPUTS = 6;
  localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h40; // arbitrary value
  // register addresses
  localparam logic [7:0] ADDR_ROUTE_12 = 8'h00;
  localparam logic [7:0] ADDR_ROUTE_34 = 8'h01;
  localparam logic [7:0] ADDR_ROUTE_56 = 8'h02;
  localparam logic [7:0] ADDR_CLAMP = 8'h03;
  localparam logic [7:0] ADDR_GAIN = 8'h04;
  // field layout
  localparam int SRC_W = 4;
  localparam int SRC_ODD_LSB = 0;
  localparam int SRC_EVEN_LSB = 4;
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_MAX = 4'h8;
  localparam int GAIN_BITS = 6;
  // reset values
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [7:0] CLAMP_RESET = 8'h00;
  localparam logic [7:0] GAIN_RESET = 8'h00;
  localparam logic [31:0] ID_VALUE = 32'h5843_5031; // arbitrary value
  // wishbone map (word addresses, byte offsets)
  localparam logic [7:0] WB_ROUTE_12 = 8'h00;
  localparam logic [7:0] WB_ROUTE_34 = 8'h04;
  localparam logic [7:0] WB_ROUTE_56 = 8'h08;
  localparam logic [7:0] WB_CLAMP = 8'h0C;
  localparam logic [7:0] WB_GAIN = 8'h10;
  localparam logic [7:0] WB_CTRL = 8'h14;
  localparam logic [7:0] WB_STATUS = 8'h18;
  localparam logic [7:0] WB_ID = 8'h1C;
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_EN_BIT = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0140;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int SCL_MAX_HZ = 100_000;
  localparam int SCL_MIN_CYC = CLK_HZ / SCL_MAX_HZ;
endpackage

/* hw/xpt_line_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser with edge detection on the synchronised level
module xpt_line_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk_i,   // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic line_i,  // raw pin level
  output logic level_o,     // synchronised level
  output logic rise_o,      // one-cycle rise pulse
  output logic fall_o       // one-cycle fall pulse
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // first flop read only by the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= RESET_LEVEL;
      sync_reg <= RESET_LEVEL;
      prev_reg <= RESET_LEVEL;
    end else begin
      meta_reg <= line_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~prev_reg;
  assign fall_o = ~sync_reg & prev_reg;
endmodule

/* hw/xpt_i2c_port.sv */
`timescale 1ns/1ps
// write-only two-wire target port that programs the crosspoint settings
// Summary of operation
// R1 - writes only; a read request is not acknowledged and returns nothing.
// R2 - standard-mode target, clock up to 100 kHz.
// R3 - master starts transfers only on an idle bus.
// R4 - one bit per clock pulse; data stable while clock is high.
// R5 - data change while clock high is a control event, not data.
// R6 - both lines high when idle; nobody holds them low.
// R7 - data falling while clock high is start; byte reception restarts.
// R8 - data rising while clock high is stop; port returns to idle.
// R9 - no limit on data bytes between start and stop.
// R10 - each byte is eight bits followed by an acknowledge slot.
// R11 - master gives a ninth clock pulse for acknowledge.
// R12 - every byte received while addressed is acknowledged.
// R13 - acknowledge holds data low through the ninth pulse's high phase.
// R14 - first byte after start is the address, compared before anything else.
// R15 - each input's clamp or bias chosen by its own bit.
// R16 - an unrouted output stays enabled unless explicitly turned off.
// R17 - software should pick bias for dc-coupled inputs.
// R18 - addresses 0 to 2 hold two source nibbles, odd low, even high.
// R19 - source none powers the output down and makes it high impedance.
// R20 - address 3 holds clamp bits, bit n-1 for input n, one is clamp.
// R21 - address 4 holds gain bits 5..0, zero is 6dB, one is unity.
// R22 - transfer is address byte, register address, data; update after ack.
// R23 - a mismatched address is not acknowledged and the transfer is ignored.
module xpt_i2c_port #(
  parameter int NUM_IN = xpt_cfg_pkg::NUM_INPUTS,
  parameter int NUM_OUT = xpt_cfg_pkg::NUM_OUTPUTS
) (
  input wire logic CLK_I,                   // 10 MHz system clock
  input wire logic RST_N_I,                 // async reset, active low
  input wire logic SCL_I,                   // serial clock pin
  input wire logic SDA_I,                   // serial data pin level
  output logic SDA_O,                       // serial data drive value (always 0)
  output logic SDA_OE_O,                    // serial data pull-down enable
  input wire logic [31:0] DAT_I,            // wishbone write data
  output logic [31:0] DAT_O,                // wishbone read data
  input wire logic [7:0] ADR_I,             // wishbone byte address
  input wire logic [3:0] SEL_I,             // wishbone byte selects
  input wire logic WE_I,                    // wishbone write enable
  input wire logic CYC_I,                   // wishbone cycle
  input wire logic STB_I,                   // wishbone strobe
  output logic ACK_O,                       // wishbone acknowledge
  output logic [4*NUM_OUT-1:0] OUT_SRC_O,   // per-output source code
  output logic [NUM_OUT-1:0] OUT_EN_O,      // output amplifier enabled
  output logic [NUM_IN-1:0] IN_CLAMP_O,     // 1 clamp, 0 bias per input
  output logic [NUM_OUT-1:0] OUT_UNITY_O    // 1 unity gain, 0 6dB
);
  // elaboration checks: field packing is fixed at eight inputs, six outputs
  if (NUM_IN != xpt_cfg_pkg::NUM_INPUTS || NUM_OUT != xpt_cfg_pkg::NUM_OUTPUTS) begin : g_bad_size
    $error("xpt_i2c_port supports exactly 8 inputs and 6 outputs");
  end
  // edge detection needs several system clocks per standard-mode link bit
  if (xpt_cfg_pkg::SCL_MIN_CYC < 8) begin : g_slow_clock // R2
    $error("system clock too slow for the serial link");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_DATA = 3'b011,
    ST_DATA_ACK = 3'b100,
    ST_IGNORE = 3'b101
  } port_state_e;

  logic scl_lvl, scl_rise, scl_fall;
  logic sda_lvl, sda_rise, sda_fall;
  logic start_evt, stop_evt;
  port_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [1:0] byte_idx_reg;
  logic [7:0] reg_addr_reg;
  logic [7:0] route_reg [0:2];
  logic [7:0] clamp_reg;
  logic [7:0] gain_reg;
  logic [7:0] ctrl_addr_reg;
  logic ctrl_en_reg;
  logic ack_drive_reg;
  logic commit_reg;
  logic [15:0] wr_count_reg;
  logic nack_seen_reg;
  logic wb_ack_reg;
  logic [31:0] wb_dat_reg;
  logic wb_req;

  xpt_line_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .line_i(SCL_I),
    .level_o(scl_lvl),
    .rise_o(scl_rise),
    .fall_o(scl_fall)
  );

  xpt_line_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .line_i(SDA_I),
    .level_o(sda_lvl),
    .rise_o(sda_rise),
    .fall_o(sda_fall)
  );

  // data edge while clock high is a control event
  assign start_evt = sda_fall & scl_lvl; // R5 R7
  assign stop_evt = sda_rise & scl_lvl; // R5 R8

  // address byte match against software-set address, write direction only
  function automatic logic addr_hit(input logic [7:0] b, input logic [6:0] own);
    addr_hit = (b[7:1] == own) && (b[0] == 1'b0); // R1 R23
  endfunction

  // protocol engine; bits shift on clock rise, decisions on clock fall
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      ack_drive_reg <= 1'b0;
      commit_reg <= 1'b0;
      nack_seen_reg <= 1'b0;
    end else begin
      commit_reg <= 1'b0;
      if (!ctrl_en_reg || stop_evt) begin
        state_reg <= ST_IDLE; // R8
        ack_drive_reg <= 1'b0; // R6
      end else if (start_evt) begin
        state_reg <= ST_ADDR; // R7 R14
        bit_cnt_reg <= 4'h0;
        byte_idx_reg <= 2'h0;
        ack_drive_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            ack_drive_reg <= 1'b0;
          end
          ST_ADDR, ST_DATA: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_lvl}; // R4
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin // R10
              bit_cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (addr_hit(shift_reg, ctrl_addr_reg[6:0])) begin
                  ack_drive_reg <= 1'b1; // R12 R13
                  state_reg <= ST_ADDR_ACK;
                end else begin
                  nack_seen_reg <= 1'b1;
                  state_reg <= ST_IGNORE; // R23
                end
              end else begin
                ack_drive_reg <= 1'b1; // R12 R13 R9
                state_reg <= ST_DATA_ACK;
              end
            end
          end
          ST_ADDR_ACK, ST_DATA_ACK: begin
            // release after the ninth pulse falls
            if (scl_fall) begin // R11
              ack_drive_reg <= 1'b0;
              if (state_reg == ST_DATA_ACK && byte_idx_reg != 2'h0) begin
                commit_reg <= 1'b1; // R22
              end
              if (state_reg == ST_DATA_ACK && byte_idx_reg == 2'h0) begin
                byte_idx_reg <= 2'h1;
              end else if (state_reg == ST_DATA_ACK) begin
                byte_idx_reg <= 2'h2;
              end
              state_reg <= ST_DATA;
            end
          end
          ST_IGNORE: begin
            ack_drive_reg <= 1'b0;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // register address byte latches; data byte auto-increments address
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      reg_addr_reg <= 8'h00;
    end else if (state_reg == ST_DATA_ACK && scl_fall && byte_idx_reg == 2'h0) begin
      reg_addr_reg <= shift_reg; // R22
    end else if (commit_reg) begin
      reg_addr_reg <= reg_addr_reg + 8'h01; // R9
    end
  end

  assign wb_req = CYC_I & STB_I & ~wb_ack_reg;

  // crosspoint settings written from the serial side or from software
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      route_reg[0] <= xpt_cfg_pkg::ROUTE_RESET;
      route_reg[1] <= xpt_cfg_pkg::ROUTE_RESET;
      route_reg[2] <= xpt_cfg_pkg::ROUTE_RESET;
      clamp_reg <= xpt_cfg_pkg::CLAMP_RESET;
      gain_reg <= xpt_cfg_pkg::GAIN_RESET;
    end else if (commit_reg) begin
      // serial write has priority; wishbone write in same cycle is lost
      case (reg_addr_reg)
        xpt_cfg_pkg::ADDR_ROUTE_12: route_reg[0] <= shift_reg; // R18
        xpt_cfg_pkg::ADDR_ROUTE_34: route_reg[1] <= shift_reg; // R18
        xpt_cfg_pkg::ADDR_ROUTE_56: route_reg[2] <= shift_reg; // R18
        xpt_cfg_pkg::ADDR_CLAMP: clamp_reg <= shift_reg; // R15 R20
        xpt_cfg_pkg::ADDR_GAIN: gain_reg <= shift_reg; // R21
        default: begin
        end
      endcase
    end else if (wb_req && WE_I && SEL_I[0]) begin
      case (ADR_I)
        xpt_cfg_pkg::WB_ROUTE_12: route_reg[0] <= DAT_I[7:0];
        xpt_cfg_pkg::WB_ROUTE_34: route_reg[1] <= DAT_I[7:0];
        xpt_cfg_pkg::WB_ROUTE_56: route_reg[2] <= DAT_I[7:0];
        xpt_cfg_pkg::WB_CLAMP: clamp_reg <= DAT_I[7:0];
        xpt_cfg_pkg::WB_GAIN: gain_reg <= DAT_I[7:0];
        default: begin
        end
      endcase
    end
  end

  // control register: own target address and port enable
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_addr_reg <= xpt_cfg_pkg::CTRL_RESET[7:0];
      ctrl_en_reg <= xpt_cfg_pkg::CTRL_RESET[xpt_cfg_pkg::CTRL_EN_BIT];
    end else if (wb_req && WE_I && ADR_I == xpt_cfg_pkg::WB_CTRL) begin
      if (SEL_I[0]) begin
        ctrl_addr_reg <= {1'b0, DAT_I[6:0]};
      end
      if (SEL_I[1]) begin
        ctrl_en_reg <= DAT_I[xpt_cfg_pkg::CTRL_EN_BIT];
      end
    end
  end

  // serial write counter, saturating
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_count_reg <= 16'h0000;
    end else if (commit_reg && wr_count_reg != 16'hFFFF) begin
      wr_count_reg <= wr_count_reg + 16'h0001;
    end
  end

  // wishbone slave: registered ack one clock after the request, read data registered with it
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0000_0000;
    end else begin
      wb_ack_reg <= wb_req;
      if (wb_req && !WE_I) begin
        case (ADR_I)
          xpt_cfg_pkg::WB_ROUTE_12: wb_dat_reg <= {24'h000000, route_reg[0]};
          xpt_cfg_pkg::WB_ROUTE_34: wb_dat_reg <= {24'h000000, route_reg[1]};
          xpt_cfg_pkg::WB_ROUTE_56: wb_dat_reg <= {24'h000000, route_reg[2]};
          xpt_cfg_pkg::WB_CLAMP: wb_dat_reg <= {24'h000000, clamp_reg};
          xpt_cfg_pkg::WB_GAIN: wb_dat_reg <= {24'h000000, 2'h0, gain_reg[5:0]};
          xpt_cfg_pkg::WB_CTRL: wb_dat_reg <= {23'h000000, ctrl_en_reg, ctrl_addr_reg};
          xpt_cfg_pkg::WB_STATUS: wb_dat_reg <= {wr_count_reg, 11'h000, nack_seen_reg,
                                                 1'b0, state_reg};
          xpt_cfg_pkg::WB_ID: wb_dat_reg <= xpt_cfg_pkg::ID_VALUE;
          default: wb_dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // output drives, all from flops
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      OUT_SRC_O <= '0;
      OUT_EN_O <= '0;
      IN_CLAMP_O <= '0;
      OUT_UNITY_O <= '0;
    end else begin
      for (int k = 0; k < NUM_OUT; k++) begin
        OUT_SRC_O[4*k +: 4] <= route_reg[k/2][4*(k%2) +: 4];
        // only the explicit none code disables an output
        OUT_EN_O[k] <= route_reg[k/2][4*(k%2) +: 4] != xpt_cfg_pkg::SRC_NONE; // R16 R19
      end
      IN_CLAMP_O <= clamp_reg; // R15 R20
      OUT_UNITY_O <= gain_reg[5:0]; // R21
    end
  end

  assign SDA_O = 1'b0;
  assign SDA_OE_O = ack_drive_reg; // R13
  assign ACK_O = wb_ack_reg;
  assign DAT_O = wb_dat_reg;

  // assertions
  a_ack_only_in_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R13
    ack_drive_reg |-> (state_reg == ST_ADDR_ACK || state_reg == ST_DATA_ACK))
    else $error("data line driven outside acknowledge slot");
  a_stop_idles: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R8
    stop_evt |=> (state_reg == ST_IDLE && !ack_drive_reg))
    else $error("stop did not return to idle");
  a_start_restarts: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R7
    (start_evt && ctrl_en_reg && !stop_evt) |=> (state_reg == ST_ADDR && bit_cnt_reg == 4'h0))
    else $error("start did not restart reception");
  a_mismatch_nack: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R23
    (state_reg == ST_IGNORE) |-> !ack_drive_reg)
    else $error("ignored transfer acknowledged");
  a_data_acked: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R12
    (state_reg == ST_DATA && scl_fall && bit_cnt_reg == 4'h8 && !start_evt && !stop_evt && ctrl_en_reg)
    |=> ack_drive_reg)
    else $error("data byte not acknowledged");
  a_read_refused: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R1
    (state_reg == ST_ADDR && scl_fall && bit_cnt_reg == 4'h8 && shift_reg[0]
     && ctrl_en_reg && !start_evt && !stop_evt) |=> (state_reg == ST_IGNORE && !ack_drive_reg))
    else $error("read request acknowledged");
  a_commit_after_ack: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R22
    commit_reg |-> $past(state_reg) == ST_DATA_ACK)
    else $error("write committed outside acknowledge");
  a_gain_update: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R21
    (commit_reg && reg_addr_reg == xpt_cfg_pkg::ADDR_GAIN) |=> ##1 OUT_UNITY_O == $past(shift_reg[5:0], 2))
    else $error("gain not applied");
  a_route_update: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R18
    (commit_reg && reg_addr_reg == xpt_cfg_pkg::ADDR_ROUTE_12) |=> ##1 OUT_SRC_O[7:0] == $past(shift_reg, 2))
    else $error("route pair not applied");
  a_clamp_update: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R20
    (commit_reg && reg_addr_reg == xpt_cfg_pkg::ADDR_CLAMP) |=> ##1 IN_CLAMP_O == $past(shift_reg, 2))
    else $error("clamp bits not applied");
  a_off_disables: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R19
    (route_reg[0][3:0] == xpt_cfg_pkg::SRC_NONE) |=> !OUT_EN_O[0])
    else $error("unrouted output not powered down");
  c_write_commit: cover property (@(posedge CLK_I) disable iff (!RST_N_I) commit_reg);
  c_nack: cover property (@(posedge CLK_I) disable iff (!RST_N_I) state_reg == ST_IGNORE);
  c_wb_read: cover property (@(posedge CLK_I) disable iff (!RST_N_I) wb_ack_reg && !WE_I);
  c_ack_slot: cover property (@(posedge CLK_I) disable iff (!RST_N_I) ack_drive_reg && scl_rise);
endmodule

/* bench/xpt_i2c_master_model.sv */
`timescale 1ns/1ps
// two-wire bus master model driving the crosspoint port's serial pins
module xpt_i2c_master_model (
  input wire logic sda_i,  // resolved data wire
  output logic scl_o,      // serial clock, idle high
  output logic sda_low_o,  // high while master pulls data low
  output logic ack_o,      // last acknowledge seen
  output int ack_cnt_o     // bumps after each acknowledge slot
);
  localparam time HALF = 400;
  // clock stands still high between frames, data released
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    ack_o = 1'b0;
    ack_cnt_o = 0;
  end
  // start marker, also a repeated start when the clock is low
  task automatic start_cond();
    // step off the system clock's rising edge so the pins never race its sampling
    #30;
    if (scl_o == 1'b0) begin
      sda_low_o = 1'b0;
      #(HALF / 2);
      scl_o = 1'b1;
      #(HALF / 2);
    end
    sda_low_o = 1'b1;
    #HALF;
    scl_o = 1'b0;
  endtask
  // stop marker, then bus free time so the next start finds it idle
  task automatic stop_cond();
    #(HALF / 2);
    sda_low_o = 1'b1;
    #(HALF / 2);
    scl_o = 1'b1;
    #HALF;
    sda_low_o = 1'b0;
    #(HALF - 30);
  endtask
  // data set mid-low and held through the whole high phase
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      #(HALF / 2);
      sda_low_o = ~b[i];
      #(HALF / 2);
      scl_o = 1'b1;
      #HALF;
      scl_o = 1'b0;
    end
  endtask
  // eight bits msb first, then a ninth pulse with data released
  task automatic send_byte(input logic [7:0] b);
    logic a;
    send_bits(b, 8);
    #(HALF / 2);
    sda_low_o = 1'b0;
    #(HALF / 2);
    scl_o = 1'b1;
    #10;
    a = ~sda_i;
    #(HALF - 20);
    a = a & ~sda_i; // low at both ends of the high phase
    #10;
    scl_o = 1'b0;
    ack_o = a;
    ack_cnt_o = ack_cnt_o + 1;
  endtask
endmodule

/* bench/xpt_i2c_port_bench.sv */
`timescale 1ns/1ps
// self-checking bench for the crosspoint two-wire write port
module xpt_i2c_port_bench;
  logic CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic [31:0] DAT_I = 32'h0;
  logic [7:0] ADR_I = 8'h00;
  logic [3:0] SEL_I = 4'h0;
  logic WE_I = 1'b0;
  logic CYC_I = 1'b0;
  logic STB_I = 1'b0;
  logic SDA_O, SDA_OE_O, ACK_O, scl, sda_low, sda, ack_bit;
  logic [31:0] DAT_O;
  logic [23:0] OUT_SRC_O;
  logic [5:0] OUT_EN_O, OUT_UNITY_O;
  logic [7:0] IN_CLAMP_O, c, g;
  logic [7:0] bad[2] = '{8'h82, 8'h81};
  int n_fail = 0, n_checks = 0, seed = 11;
  int ack_cnt;
  logic [31:0] exp_rd[$];
  logic exp_ack[$];
  always #50 CLK_I = ~CLK_I;
  // open-drain data wire with pull-up
  assign sda = sda_low ? 1'b0 : (SDA_OE_O ? SDA_O : 1'b1);
  xpt_i2c_port dut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .SCL_I(scl), .SDA_I(sda), .SDA_O(SDA_O),
    .SDA_OE_O(SDA_OE_O), .DAT_I(DAT_I), .DAT_O(DAT_O), .ADR_I(ADR_I), .SEL_I(SEL_I), .WE_I(WE_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .OUT_SRC_O(OUT_SRC_O), .OUT_EN_O(OUT_EN_O),
    .IN_CLAMP_O(IN_CLAMP_O), .OUT_UNITY_O(OUT_UNITY_O));
  xpt_i2c_master_model m (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low), .ack_o(ack_bit),
    .ack_cnt_o(ack_cnt));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= a;
    DAT_I <= d;
    SEL_I <= 4'hF;
    for (i = 0; i < 20; i++) begin
      @(posedge CLK_I);
      if (ACK_O === 1'b1) break;
    end
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
    if (i == 20) begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // read data is judged at the edge where ack is high
  always @(posedge CLK_I) begin
    if (ACK_O === 1'b1 && WE_I === 1'b0 && exp_rd.size() > 0) begin
      chk("read data", exp_rd.pop_front(), DAT_O);
    end
  end
  task automatic sb(input logic [7:0] b, input logic e);
    exp_ack.push_back(e);
    m.send_byte(b);
  endtask
  // each acknowledge slot the model reports takes the oldest note
  always @(ack_cnt) begin
    if (exp_ack.size() > 0) begin
      chk("serial ack", {31'h0, exp_ack.pop_front()}, {31'h0, ack_bit});
    end
  end
  task automatic wr_frame(input logic [7:0] r, input logic [7:0] d);
    m.start_cond();
    sb({xpt_cfg_pkg::TARGET_ADDR_DEFAULT, 1'b0}, 1'b1);
    sb(r, 1'b1);
    sb(d, 1'b1);
    m.stop_cond();
  endtask
  // commit lands a couple of clocks after the last ack
  task automatic outs(input logic [23:0] s, input logic [5:0] en);
    repeat (4) @(posedge CLK_I);
    chk("source", {8'h0, s}, {8'h0, OUT_SRC_O});
    chk("enable", {26'h0, en}, {26'h0, OUT_EN_O});
  endtask
  initial begin
    c = 8'h00;
    g = 8'h00;
    repeat (6) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    // reset values and the map, unmapped place included
    rd(xpt_cfg_pkg::WB_ROUTE_12, 32'h0);
    rd(xpt_cfg_pkg::WB_ROUTE_56, 32'h0);
    rd(xpt_cfg_pkg::WB_CLAMP, 32'h0);
    rd(xpt_cfg_pkg::WB_GAIN, 32'h0);
    rd(xpt_cfg_pkg::WB_CTRL, xpt_cfg_pkg::CTRL_RESET);
    rd(xpt_cfg_pkg::WB_ID, xpt_cfg_pkg::ID_VALUE);
    rd(xpt_cfg_pkg::WB_STATUS, 32'h0000_0000);
    rd(8'h20, 32'h0);
    outs(24'h000000, 6'h00);
    // one frame, several data bytes with auto-increment
    m.start_cond();
    sb(8'h80, 1'b1);
    sb(8'h00, 1'b1);
    sb(8'h21, 1'b1);
    sb(8'h43, 1'b1);
    sb(8'h05, 1'b1);
    m.stop_cond();
    outs(24'h054321, 6'h1F);
    // random clamp choice, input eight taken as dc-coupled
    c = 8'($random(seed)) & 8'h7F;
    wr_frame(xpt_cfg_pkg::ADDR_CLAMP, c);
    chk("clamp", {24'h0, c}, {24'h0, IN_CLAMP_O});
    rd(xpt_cfg_pkg::WB_CLAMP, {24'h0, c});
    g = 8'($random(seed)) | 8'hC0;
    wr_frame(xpt_cfg_pkg::ADDR_GAIN, g);
    repeat (4) @(posedge CLK_I);
    chk("gain", {26'h0, g[5:0]}, {26'h0, OUT_UNITY_O});
    // foreign address, then a read request: nothing acked or stored
    foreach (bad[i]) begin
      m.start_cond();
      sb(bad[i], 1'b0);
      sb(8'h00, 1'b0);
      sb(8'hFF, 1'b0);
      m.stop_cond();
    end
    outs(24'h054321, 6'h1F);
    // stop before any data byte leaves the registers alone
    m.start_cond();
    sb(8'h80, 1'b1);
    sb(8'h00, 1'b1);
    m.stop_cond();
    outs(24'h054321, 6'h1F);
    // start in mid-byte restarts reception
    m.start_cond();
    m.send_bits(8'hA5, 4);
    wr_frame(xpt_cfg_pkg::ADDR_ROUTE_34, 8'h07);
    outs(24'h050721, 6'h17);
    // register bus write to the last route pair
    wb(1'b1, xpt_cfg_pkg::WB_ROUTE_56, 32'h78);
    outs(24'h780721, 6'h37);
    rd(xpt_cfg_pkg::WB_ROUTE_56, 32'h78);
    // port switched off: an addressed frame gets no answer
    wb(1'b1, xpt_cfg_pkg::WB_CTRL, 32'h0000_0040);
    m.start_cond();
    sb(8'h80, 1'b0);
    m.stop_cond();
    // back on at a new own address; that address answers
    wb(1'b1, xpt_cfg_pkg::WB_CTRL, 32'h0000_0141);
    rd(xpt_cfg_pkg::WB_CTRL, 32'h0000_0141);
    m.start_cond();
    sb(8'h82, 1'b1);
    sb(xpt_cfg_pkg::ADDR_GAIN, 1'b1);
    sb(8'h3F, 1'b1);
    m.stop_cond();
    repeat (4) @(posedge CLK_I);
    chk("gain", 32'h0000_003F, {26'h0, OUT_UNITY_O});
    // seven serial writes so far, one foreign address seen, engine idle
    rd(xpt_cfg_pkg::WB_STATUS, 32'h0007_0010);
    repeat (2) @(posedge CLK_I);
    final_report();
  end
endmodule
